// >>> rtl/shim_defs.svh
`ifndef SHIM_DEFS_SVH
`define SHIM_DEFS_SVH

// data path width in bits and bytes
`define SHIM_DATA_W      64
`define SHIM_KEEP_W      8
// remainder field width (byte count minus one)
`define SHIM_REM_W       3
// user flow control message size width
`define SHIM_UFC_MS_W    3
// native flow control pause field width
`define SHIM_NFC_PAUSE_W 4
// user k-block number width
`define SHIM_KBLK_W      3
// fifo depth in words
`define SHIM_FIFO_DEPTH  16
// reset value of the frame-open flags (no frame open)
`define SHIM_IN_FRAME_RST 1'b0

`endif

// >>> rtl/shim_pkg.sv
`default_nettype none
`include "shim_defs.svh"

package shim_pkg;

   // one data beat on the stream side
   typedef struct packed {
      logic [`SHIM_DATA_W-1:0] data;   // payload word
      logic [`SHIM_KEEP_W-1:0] keep;   // byte keep mask
      logic                    last;   // frame end
   } stream_beat_t;

   // one data beat on the legacy side, markers active low
   typedef struct packed {
      logic [`SHIM_DATA_W-1:0] data;   // payload word
      logic [`SHIM_REM_W-1:0]  rem;    // valid bytes minus one
      logic                    sofLow; // start marker
      logic                    eofLow; // end marker
   } legacy_beat_t;

   // frame tracker states
   typedef enum logic [0:0] {
      FR_IDLE = 1'b0,
      FR_BODY = 1'b1
   } frame_state_t;

endpackage

`default_nettype wire

// >>> rtl/shim_fifo.sv
`default_nettype none

module shim_fifo #(
   parameter int WIDTH = 72,
   parameter int DEPTH = 16
) (
   input  wire logic             ref_clk,
   input  wire logic             rstSyncN,
   input  wire logic             clkEn,
   input  wire logic [WIDTH-1:0] inData,
   input  wire logic             inValid,
   output logic                  inReady,
   output logic      [WIDTH-1:0] outData,
   output logic                  outValid,
   input  wire logic             outReady
);

   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];   // storage array
   logic [AW-1:0]    wrPtr_q;       // write index
   logic [AW-1:0]    rdPtr_q;       // read index
   logic [AW:0]      count_q;       // words held
   logic             doWrite;       // accepted push
   logic             doRead;        // accepted pop

   // full at depth, empty at zero
   assign inReady  = (count_q != (AW+1)'(DEPTH));
   assign outValid = (count_q != '0);
   assign doWrite  = clkEn & inValid & inReady;
   assign doRead   = clkEn & outValid & outReady;
   assign outData  = mem[rdPtr_q];

   // storage write, no reset needed
   always_ff @(posedge ref_clk) begin
      if (doWrite) begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers and occupancy
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         wrPtr_q <= '0;
         rdPtr_q <= '0;
         count_q <= '0;
      end else begin
         if (doWrite) begin
            wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
         end
         if (doRead) begin
            rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
         end
         if (doWrite & ~doRead) begin
            count_q <= count_q + 1'b1;
         end else if (doRead & ~doWrite) begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule

`default_nettype wire

// >>> rtl/stream_to_legacy_frame_shim.sv
`default_nettype none
`include "shim_defs.svh"

module stream_to_legacy_frame_shim
   import shim_pkg::*;
(
   input  wire logic                          ref_clk,
   input  wire logic                          rstn,
   input  wire logic                          clkEn,
   // legacy transmit data side
   input  wire logic [`SHIM_DATA_W-1:0]       legacyTxData,
   input  wire logic [`SHIM_REM_W-1:0]        legacy_transmit_remainder,
   input  wire logic                          legacyTxEofLow,
   input  wire logic                          legacyTxSrcReadyLow,
   output logic                               legacy_transmit_sink_ready_low,
   output logic                               legacyTxSofLow,
   // stream transmit data side
   output logic [`SHIM_DATA_W-1:0]            s_axi_tx_tdata,
   output logic [`SHIM_KEEP_W-1:0]            s_axi_tx_tkeep,
   output logic                               s_axi_tx_tlast,
   output logic                               s_axi_tx_tvalid,
   input  wire logic                          s_axi_tx_tready,
   // user flow control transmit
   input  wire logic                          legacyUfcReqLow,
   input  wire logic [`SHIM_UFC_MS_W-1:0]     user_flow_message_size,
   input  wire logic [`SHIM_DATA_W-1:0]       legacyUfcTxData,
   input  wire logic                          legacyUfcSrcReadyLow,
   output logic                               legacy_user_flow_sink_ready_low,
   output logic                               ufc_tx_req,
   output logic [`SHIM_UFC_MS_W-1:0]          user_flow_size_field,
   output logic [`SHIM_DATA_W-1:0]            s_axi_ufc_tx_tdata,
   output logic                               s_axi_ufc_tx_tvalid,
   input  wire logic                          s_axi_ufc_tx_tready,
   // native flow control transmit
   input  wire logic                          legacyNfcReqLow,
   output logic                               legacyNfcAckLow,
   input  wire logic [`SHIM_NFC_PAUSE_W-1:0]  legacyNfcPause,
   input  wire logic                          native_flow_stop_flag,
   output logic                               s_axi_nfc_tx_tvalid,
   input  wire logic                          s_axi_nfc_tx_tready,
   output logic [`SHIM_NFC_PAUSE_W:0]         s_axi_nfc_tx_tdata,
   // user k-block transmit
   input  wire logic [`SHIM_DATA_W-1:0]       legacyKData,
   input  wire logic [`SHIM_KBLK_W-1:0]       kblock_number,
   input  wire logic                          legacyKSrcReadyLow,
   output logic                               legacy_kblock_sink_ready_low,
   output logic [`SHIM_DATA_W+`SHIM_KBLK_W-1:0] s_axi_user_k_tdata,
   output logic                               s_axi_user_k_tx_tvalid,
   input  wire logic                          s_axi_user_k_tx_tready,
   // stream receive data side
   input  wire logic [`SHIM_DATA_W-1:0]       m_axi_rx_tdata,
   input  wire logic [`SHIM_KEEP_W-1:0]       m_axi_rx_tkeep,
   input  wire logic                          m_axi_rx_tlast,
   input  wire logic                          m_axi_rx_tvalid,
   output logic                               m_axi_rx_tready,
   // legacy receive data side, stalls via legacyRxSinkReadyLow
   output logic [`SHIM_DATA_W-1:0]            legacyRxData,
   output logic [`SHIM_REM_W-1:0]             legacy_receive_remainder,
   output logic                               legacyRxSofLow,
   output logic                               legacyRxEofLow,
   output logic                               legacyRxSrcReadyLow,
   input  wire logic                          legacyRxSinkReadyLow,
   // user flow control receive
   input  wire logic [`SHIM_DATA_W-1:0]       m_axi_ufc_rx_tdata,
   input  wire logic [`SHIM_KEEP_W-1:0]       m_axi_ufc_rx_tkeep,
   input  wire logic                          m_axi_ufc_rx_tlast,
   input  wire logic                          m_axi_ufc_rx_tvalid,
   output logic [`SHIM_DATA_W-1:0]            legacyUfcRxData,
   output logic [`SHIM_REM_W-1:0]             legacyUfcRxRem,
   output logic                               legacyUfcRxSofLow,
   output logic                               legacyUfcRxEofLow,
   output logic                               legacyUfcRxSrcReadyLow,
   // user k-block receive
   input  wire logic [`SHIM_DATA_W+`SHIM_KBLK_W-1:0] m_axi_user_k_rx_tdata,
   input  wire logic                          m_axi_user_k_rx_tvalid,
   output logic [`SHIM_DATA_W-1:0]            legacyRxKData,
   output logic [`SHIM_KBLK_W-1:0]            legacyRxKBlockNum,
   output logic                               legacyRxKSrcReadyLow
);

   // reset release
   logic rstMeta_q;     // first release stage
   logic rstSyncN;      // released reset copy

   // rstSyncN asserts at once with rstn and releases on the clock,
   // so no flop leaves reset between two edges
   // two-stage reset release
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_q <= 1'b0;
         rstSyncN  <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSyncN  <= rstMeta_q;
      end
   end

   // keep and remainder helpers
   // keep is taken as contiguous from the top lane;
   // a full mask yields seven, the legacy body value
   // count of leading valid bytes minus one, for contiguous keep
   function automatic logic [`SHIM_REM_W-1:0] keepToRem(input logic [`SHIM_KEEP_W-1:0] k);
      logic [`SHIM_REM_W-1:0] r;
      r = '0;
      for (int i = 1; i < `SHIM_KEEP_W; i++) begin
         if (k[`SHIM_KEEP_W-1-i]) begin
            r = `SHIM_REM_W'(i);
         end
      end
      return r;
   endfunction

   // one compare per lane: lane g kept when g <= remainder
   // thermometer keep mask from remainder, lane 0 in msb
   logic [`SHIM_KEEP_W-1:0] txKeepFull;   // mask for the final beat
   genvar g;
   generate
      for (g = 0; g < `SHIM_KEEP_W; g++) begin : gKeep
         assign txKeepFull[`SHIM_KEEP_W-1-g] = (`SHIM_REM_W'(g) <= legacy_transmit_remainder);
      end
   endgenerate

   // one adapter per interface direction
   // each interface below has a transmit half, and all but native flow
   // control a receive half; none shares state with another
   // transmit data path, combinational but the frame flag
   logic txValid;       // active-high source ready
   logic txEnd;         // active-high end marker
   logic txFire;        // beat handed over
   logic txInFrame_q;   // frame open on transmit
   logic txInFrame_d;

   assign txValid = ~legacyTxSrcReadyLow;
   assign txEnd   = ~legacyTxEofLow;
   assign s_axi_tx_tvalid = txValid;
   assign s_axi_tx_tlast  = txEnd;
   assign s_axi_tx_tdata  = legacyTxData;
   // only the closing beat narrows the keep mask
   // full keep on body beats
   assign s_axi_tx_tkeep  = txEnd ? txKeepFull : {`SHIM_KEEP_W{1'b1}};
   assign legacy_transmit_sink_ready_low = ~s_axi_tx_tready;
   // a beat is handed over only when both sides agree
   assign txFire = txValid & s_axi_tx_tready;
   // start marker low while a valid beat finds no frame open
   // start on first beat of frame
   assign legacyTxSofLow = ~(txValid & ~txInFrame_q);
   // a taken end beat closes the frame, other taken beats open it
   assign txInFrame_d = txFire ? ~txEnd : txInFrame_q;

   // clkEn low holds the flag, so a frozen cycle never
   // opens or closes a frame
   // transmit frame tracker
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         txInFrame_q <= `SHIM_IN_FRAME_RST;
      end else if (clkEn) begin
         txInFrame_q <= txInFrame_d;
      end
   end

   // user flow control transmit
   // pure wiring: no state, no added latency
   // request flip, size passes
   assign ufc_tx_req           = ~legacyUfcReqLow;
   assign user_flow_size_field = user_flow_message_size;
   assign s_axi_ufc_tx_tvalid  = ~legacyUfcSrcReadyLow;
   assign legacy_user_flow_sink_ready_low = ~s_axi_ufc_tx_tready;
   assign s_axi_ufc_tx_tdata   = legacyUfcTxData;

   // native flow control transmit
   // packing: stop flag sits above the pause count
   // request and ack flips
   assign s_axi_nfc_tx_tvalid = ~legacyNfcReqLow;
   assign legacyNfcAckLow     = ~s_axi_nfc_tx_tready;
   assign s_axi_nfc_tx_tdata  = {native_flow_stop_flag, legacyNfcPause};

   // user k-block transmit
   // block number rides above the data word
   // k-block handshake flips
   assign s_axi_user_k_tx_tvalid       = ~legacyKSrcReadyLow;
   assign legacy_kblock_sink_ready_low = ~s_axi_user_k_tx_tready;
   assign s_axi_user_k_tdata           = {kblock_number, legacyKData};

   // receive data path with fifo
   // the fifo lets the stream side burst while legacy stalls;
   // tready drops only once all sixteen words are held
   stream_beat_t rxIn;       // beat into the fifo
   stream_beat_t rxOut;      // beat at the fifo head
   logic         rxOutValid; // head holds a beat
   logic         rxPop;      // legacy side takes it
   logic         rxInFrame_q; // frame open on receive
   logic         rxInFrame_d;

   // pack the stream beat into one fifo word
   assign rxIn.data = m_axi_rx_tdata;
   assign rxIn.keep = m_axi_rx_tkeep;
   assign rxIn.last = m_axi_rx_tlast;

   // buffer between stream and legacy receive
   shim_fifo #(
      .WIDTH ($bits(stream_beat_t)),
      .DEPTH (`SHIM_FIFO_DEPTH)
   ) uRxFifo (
      .ref_clk  (ref_clk),
      .rstSyncN (rstSyncN),
      .clkEn    (clkEn),
      .inData   (rxIn),
      .inValid  (m_axi_rx_tvalid),
      .inReady  (m_axi_rx_tready),
      .outData  (rxOut),
      .outValid (rxOutValid),
      .outReady (rxPop)
   );

   // legacy sink ready low pops the head beat
   assign rxPop = ~legacyRxSinkReadyLow;
   assign legacyRxSrcReadyLow = ~rxOutValid;
   assign legacyRxEofLow = ~rxOut.last;
   assign legacyRxData = rxOut.data;
   // remainder reads the head beat's keep
   // keep to remainder
   assign legacy_receive_remainder = keepToRem(rxOut.keep);
   // start marker from the head beat and the receive flag
   // recreated start marker
   assign legacyRxSofLow = ~(rxOutValid & ~rxInFrame_q);
   // frame flag follows popped beats, not pushed ones
   assign rxInFrame_d = (rxOutValid & rxPop) ? ~rxOut.last : rxInFrame_q;

   // clkEn gates the flag together with the fifo pointers
   // receive frame tracker
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         rxInFrame_q <= `SHIM_IN_FRAME_RST;
      end else if (clkEn) begin
         rxInFrame_q <= rxInFrame_d;
      end
   end

   // user flow control receive
   // no ready here: every valid beat counts as taken
   logic ufcInFrame_q;   // flow message open
   logic ufcInFrame_d;

   assign legacyUfcRxSrcReadyLow = ~m_axi_ufc_rx_tvalid;
   assign legacyUfcRxEofLow      = ~m_axi_ufc_rx_tlast;
   assign legacyUfcRxData        = m_axi_ufc_rx_tdata;
   // same keep to remainder mapping as the data path
   assign legacyUfcRxRem         = keepToRem(m_axi_ufc_rx_tkeep);
   // start marker on the first beat of each message
   assign legacyUfcRxSofLow      = ~(m_axi_ufc_rx_tvalid & ~ufcInFrame_q);
   assign ufcInFrame_d = m_axi_ufc_rx_tvalid ? ~m_axi_ufc_rx_tlast : ufcInFrame_q;

   // frozen with clkEn like the other trackers
   // flow message tracker
   always_ff @(posedge ref_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         ufcInFrame_q <= `SHIM_IN_FRAME_RST;
      end else if (clkEn) begin
         ufcInFrame_q <= ufcInFrame_d;
      end
   end

   // user k-block receive
   // split the stream word into data and block number
   // k-block ready flip
   assign legacyRxKSrcReadyLow = ~m_axi_user_k_rx_tvalid;
   assign legacyRxKData        = m_axi_user_k_rx_tdata[`SHIM_DATA_W-1:0];
   assign legacyRxKBlockNum    = m_axi_user_k_rx_tdata[`SHIM_DATA_W+`SHIM_KBLK_W-1:`SHIM_DATA_W];

endmodule

`default_nettype wire

// >>> sim/shim_checker.sv
`default_nettype none
`include "shim_defs.svh"

// port-level relations of the frame shim, sampled on the user clock
module shim_checker (
   input wire logic                    ref_clk,
   input wire logic                    rstn,
   input wire logic                    clkEn,
   input wire logic                    legacyTxSrcReadyLow,
   input wire logic                    s_axi_tx_tvalid,
   input wire logic                    s_axi_tx_tready,
   input wire logic                    legacy_transmit_sink_ready_low,
   input wire logic                    legacyTxEofLow,
   input wire logic                    s_axi_tx_tlast,
   input wire logic                    legacyTxSofLow,
   input wire logic [`SHIM_DATA_W-1:0] legacyTxData,
   input wire logic [`SHIM_DATA_W-1:0] s_axi_tx_tdata,
   input wire logic [`SHIM_KEEP_W-1:0] s_axi_tx_tkeep,
   input wire logic [`SHIM_REM_W-1:0]  legacy_transmit_remainder,
   input wire logic                    m_axi_rx_tvalid,
   input wire logic                    m_axi_rx_tready,
   input wire logic                    legacyRxSrcReadyLow,
   input wire logic                    legacyRxSinkReadyLow,
   input wire logic [`SHIM_DATA_W-1:0] legacyRxData,
   input wire logic                    legacyRxEofLow,
   input wire logic                    legacyNfcReqLow,
   input wire logic                    s_axi_nfc_tx_tvalid,
   input wire logic                    s_axi_nfc_tx_tready,
   input wire logic                    legacyNfcAckLow,
   input wire logic                    m_axi_ufc_rx_tlast,
   input wire logic                    m_axi_ufc_rx_tvalid,
   input wire logic                    legacyUfcRxEofLow,
   input wire logic                    legacyUfcRxSrcReadyLow
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   property p_txValid;
      s_axi_tx_tvalid == !legacyTxSrcReadyLow;
   endproperty
   a_txValid: assert property (p_txValid) else $error("tx valid not inverted");
   property p_txSink;
      legacy_transmit_sink_ready_low == !s_axi_tx_tready;
   endproperty
   a_txSink: assert property (p_txSink) else $error("tx sink ready not inverted");
   property p_txLast;
      s_axi_tx_tlast == !legacyTxEofLow;
   endproperty
   a_txLast: assert property (p_txLast) else $error("tx last not inverted");
   // a taken closing beat must show the start marker in the next cycle, if that cycle has a valid beat
   property p_txSof;
      (s_axi_tx_tvalid && s_axi_tx_tready && clkEn && s_axi_tx_tlast)
         |=> (s_axi_tx_tvalid -> !legacyTxSofLow);
   endproperty
   a_txSof: assert property (p_txSof) else $error("tx start marker missing");
   property p_txData;
      s_axi_tx_tdata == legacyTxData;
   endproperty
   a_txData: assert property (p_txData) else $error("tx data altered");
   // a pushed beat is visible to the legacy side one cycle later
   property p_rxSrc;
      (m_axi_rx_tvalid && m_axi_rx_tready && clkEn) |=> !legacyRxSrcReadyLow;
   endproperty
   a_rxSrc: assert property (p_rxSrc) else $error("rx beat not offered");
   property p_rxStand;
      (!legacyRxSrcReadyLow && legacyRxSinkReadyLow)
         |=> ($stable(legacyRxData) && $stable(legacyRxEofLow) && !legacyRxSrcReadyLow);
   endproperty
   a_rxStand: assert property (p_rxStand) else $error("rx beat changed while stalled");
   property p_nfc;
      s_axi_nfc_tx_tvalid == !legacyNfcReqLow && legacyNfcAckLow == !s_axi_nfc_tx_tready;
   endproperty
   a_nfc: assert property (p_nfc) else $error("native flow handshake not inverted");
   property p_ufcRx;
      legacyUfcRxEofLow == !m_axi_ufc_rx_tlast && legacyUfcRxSrcReadyLow == !m_axi_ufc_rx_tvalid;
   endproperty
   a_ufcRx: assert property (p_ufcRx) else $error("rx flow markers not inverted");
   // keep is a thermometer from the top byte on the closing beat only
   property p_txKeep;
      s_axi_tx_tkeep == (s_axi_tx_tlast ?
         8'(8'hff << (3'd7 - legacy_transmit_remainder)) : 8'hff);
   endproperty
   a_txKeep: assert property (p_txKeep) else $error("tx keep wrong");
endmodule
`default_nettype wire

// >>> sim/legacy_rx_sink.sv
`default_nettype none

// legacy receive user logic: takes beats, stalls at random or on command
module legacy_rx_sink (
   input  wire logic ref_clk,
   input  wire logic stall,
   output logic      legacyRxSinkReadyLow
);
   timeunit 1ns;
   timeprecision 100ps;
   int seed = 32'h0000_e466;   // own stream of stall decisions

   initial legacyRxSinkReadyLow = 1'b1;
   // not ready while stalled, else ready three cycles in four
   always @(negedge ref_clk) begin
      legacyRxSinkReadyLow <= stall || (($random(seed) % 4) == 0);
   end
endmodule
`default_nettype wire

// >>> sim/tb_stream_to_legacy_frame_shim.sv
`default_nettype none
`include "shim_defs.svh"

module tb_stream_to_legacy_frame_shim;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int DW = `SHIM_DATA_W;
   localparam int KD = `SHIM_DATA_W + `SHIM_KBLK_W;
   logic [DW-1:0] legacyTxData, s_axi_tx_tdata, legacyUfcTxData, s_axi_ufc_tx_tdata, legacyKData;
   logic [DW-1:0] m_axi_rx_tdata, legacyRxData, m_axi_ufc_rx_tdata, legacyUfcRxData, legacyRxKData;
   logic [KD-1:0] s_axi_user_k_tdata, m_axi_user_k_rx_tdata;
   logic [7:0]    s_axi_tx_tkeep, m_axi_rx_tkeep, m_axi_ufc_rx_tkeep;
   logic [2:0]    legacy_transmit_remainder, user_flow_message_size, user_flow_size_field;
   logic [2:0]    kblock_number, legacy_receive_remainder, legacyUfcRxRem, legacyRxKBlockNum;
   logic [3:0]    legacyNfcPause;
   logic [4:0]    s_axi_nfc_tx_tdata;
   logic ref_clk, rstn, clkEn, legacyTxEofLow, legacyTxSrcReadyLow, legacy_transmit_sink_ready_low;
   logic legacyTxSofLow, s_axi_tx_tlast, s_axi_tx_tvalid, s_axi_tx_tready, legacyUfcReqLow;
   logic legacyUfcSrcReadyLow, legacy_user_flow_sink_ready_low, ufc_tx_req, s_axi_ufc_tx_tvalid;
   logic s_axi_ufc_tx_tready, legacyNfcReqLow, legacyNfcAckLow, native_flow_stop_flag;
   logic s_axi_nfc_tx_tvalid, s_axi_nfc_tx_tready, legacyKSrcReadyLow;
   logic legacy_kblock_sink_ready_low, legacyRxSinkReadyLow;
   logic s_axi_user_k_tx_tvalid, s_axi_user_k_tx_tready, m_axi_rx_tlast, m_axi_rx_tvalid;
   logic m_axi_rx_tready, legacyRxSofLow, legacyRxEofLow, legacyRxSrcReadyLow;
   logic m_axi_ufc_rx_tlast, m_axi_ufc_rx_tvalid, legacyUfcRxSofLow, legacyUfcRxEofLow;
   logic legacyUfcRxSrcReadyLow, m_axi_user_k_rx_tvalid, legacyRxKSrcReadyLow;
   // model state: open frames, request holds, rx beats in flight
   logic stall, run, txOpen, popOpen, ufcOpen, txHold, rxHold;
   int   seed, rxMode, n_errors, n_compared;
   shim_pkg::stream_beat_t rxQ[$];
   shim_pkg::stream_beat_t b;

   stream_to_legacy_frame_shim uut (.*);
   legacy_rx_sink partner (
      .ref_clk              (ref_clk),
      .stall                (stall),
      .legacyRxSinkReadyLow (legacyRxSinkReadyLow)
   );

   function automatic logic rb();
      return 1'($random(seed));
   endfunction
   function automatic logic [DW-1:0] rw();
      return {$random(seed), $random(seed)};
   endfunction
   // closing-beat keep: r+1 ones from the top byte down
   function automatic logic [7:0] therm(input logic [2:0] r);
      return 8'(8'hff << (3'd7 - r));
   endfunction

   task automatic chk(input string nm, input logic [127:0] seen, input logic [127:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim();
      $display("compared %0d errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // new random inputs; a pending tx or rx data beat stays as it was until taken
   task automatic drive();
      if (!txHold) begin
         legacyTxData = rw();
         legacyTxSrcReadyLow = rb();
         legacyTxEofLow = ($random(seed) % 3) != 0;
         legacy_transmit_remainder = 3'($random(seed));
      end
      if (!rxHold) begin
         m_axi_rx_tdata = rw();
         m_axi_rx_tlast = rb();
         m_axi_rx_tkeep = m_axi_rx_tlast ? therm(3'($random(seed))) : 8'hff;
         m_axi_rx_tvalid = (rxMode == 2) || (rxMode == 0 && rb());
      end
      s_axi_tx_tready = rb();
      clkEn = 3'($random(seed)) != 3'h0;
      legacyUfcReqLow = rb();
      user_flow_message_size = 3'($random(seed));
      legacyUfcTxData = rw();
      legacyUfcSrcReadyLow = rb();
      s_axi_ufc_tx_tready = rb();
      legacyNfcReqLow = rb();
      legacyNfcPause = 4'($random(seed));
      native_flow_stop_flag = rb();
      s_axi_nfc_tx_tready = rb();
      legacyKData = rw();
      kblock_number = 3'($random(seed));
      legacyKSrcReadyLow = rb();
      s_axi_user_k_tx_tready = rb();
      m_axi_ufc_rx_tdata = rw();
      m_axi_ufc_rx_tlast = rb();
      m_axi_ufc_rx_tkeep = m_axi_ufc_rx_tlast ? therm(3'($random(seed))) : 8'hff;
      m_axi_ufc_rx_tvalid = rb();
      m_axi_user_k_rx_tdata = {3'($random(seed)), rw()};
      m_axi_user_k_rx_tvalid = rb();
   endtask

   // combinational paths and fifo flags, looked at once settled
   task automatic check_all();
      logic [7:0] keepExp;   // full keep except on the closing beat
      keepExp = legacyTxEofLow ? 8'hff : therm(legacy_transmit_remainder);
      chk("tx_tvalid", s_axi_tx_tvalid, !legacyTxSrcReadyLow);
      chk("tx_sink", legacy_transmit_sink_ready_low, !s_axi_tx_tready);
      chk("tx_tlast", s_axi_tx_tlast, !legacyTxEofLow);
      if (!legacyTxSrcReadyLow) chk("tx_sof", legacyTxSofLow, txOpen);
      chk("tx_tdata", s_axi_tx_tdata, legacyTxData);
      chk("tx_tkeep", s_axi_tx_tkeep, keepExp);
      chk("ufc_req", ufc_tx_req, !legacyUfcReqLow);
      chk("ufc_size", user_flow_size_field, user_flow_message_size);
      chk("ufc_valid", s_axi_ufc_tx_tvalid, !legacyUfcSrcReadyLow);
      chk("ufc_sink", legacy_user_flow_sink_ready_low, !s_axi_ufc_tx_tready);
      chk("ufc_data", s_axi_ufc_tx_tdata, legacyUfcTxData);
      chk("nfc_valid", s_axi_nfc_tx_tvalid, !legacyNfcReqLow);
      chk("nfc_ack", legacyNfcAckLow, !s_axi_nfc_tx_tready);
      chk("nfc_data", s_axi_nfc_tx_tdata, {native_flow_stop_flag, legacyNfcPause});
      chk("k_valid", s_axi_user_k_tx_tvalid, !legacyKSrcReadyLow);
      chk("k_sink", legacy_kblock_sink_ready_low, !s_axi_user_k_tx_tready);
      chk("k_data", s_axi_user_k_tdata, {kblock_number, legacyKData});
      chk("rx_tready", m_axi_rx_tready, rxQ.size() < `SHIM_FIFO_DEPTH);
      chk("rx_src", legacyRxSrcReadyLow, rxQ.size() == 0);
      chk("ufc_rx_eof", legacyUfcRxEofLow, !m_axi_ufc_rx_tlast);
      chk("ufc_rx_src", legacyUfcRxSrcReadyLow, !m_axi_ufc_rx_tvalid);
      chk("ufc_rx_data", legacyUfcRxData, m_axi_ufc_rx_tdata);
      chk("ufc_legacy_receive_remainder", legacyUfcRxRem, $countones(m_axi_ufc_rx_tkeep) - 1);
      if (m_axi_ufc_rx_tvalid) chk("ufc_rx_sof", legacyUfcRxSofLow, ufcOpen);
      chk("k_rx_src", legacyRxKSrcReadyLow, !m_axi_user_k_rx_tvalid);
      chk("k_rx_data", {legacyRxKBlockNum, legacyRxKData}, m_axi_user_k_rx_tdata);
   endtask

   task automatic cycles(input int n);
      repeat (n) begin
         @(negedge ref_clk);
         drive();
         #2;
         check_all();
      end
   endtask

   // reference model at each edge: pops, pushes, frame flags, holds
   always @(posedge ref_clk) begin
      if (run) begin
         if (!legacyRxSrcReadyLow && !legacyRxSinkReadyLow && clkEn && rxQ.size() > 0) begin
            b = rxQ.pop_front();
            chk("rx_data", legacyRxData, b.data);
            chk("rx_eof", legacyRxEofLow, !b.last);
            chk("legacy_receive_remainder", legacy_receive_remainder, $countones(b.keep) - 1);
            chk("rx_sof", legacyRxSofLow, popOpen);
            popOpen = !b.last;
         end
         if (m_axi_rx_tvalid && m_axi_rx_tready && clkEn) begin
            rxQ.push_back('{m_axi_rx_tdata, m_axi_rx_tkeep, m_axi_rx_tlast});
         end
         if (!legacyTxSrcReadyLow && s_axi_tx_tready && clkEn) txOpen = legacyTxEofLow;
         if (m_axi_ufc_rx_tvalid && clkEn) ufcOpen = !m_axi_ufc_rx_tlast;
         txHold = !legacyTxSrcReadyLow && !(s_axi_tx_tready && clkEn);
         rxHold = m_axi_rx_tvalid && !(m_axi_rx_tready && clkEn);
      end
   end

   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   // watchdog well beyond the expected run length
   initial begin
      #(3000 * 25);
      n_errors++;
      end_sim();
   end

   // main sequence: random traffic, drain, fill to refusal, drain
   initial begin
      seed = 32'h0000_e466;
      {n_errors, n_compared, rxMode} = '0;
      {stall, run, txOpen, popOpen, ufcOpen, txHold, rxHold} = '0;
      rstn = 1'b0;
      drive();
      legacyTxSrcReadyLow = 1'b1;
      m_axi_rx_tvalid = 1'b0;
      m_axi_ufc_rx_tvalid = 1'b0;
      repeat (12) @(posedge ref_clk);
      @(negedge ref_clk) rstn = 1'b1;
      repeat (3) @(posedge ref_clk);
      run = 1'b1;
      cycles(400);
      rxMode = 1;
      cycles(40);
      stall = 1'b1;
      rxMode = 2;
      cycles(24);
      stall = 1'b0;
      rxMode = 1;
      cycles(40);
      end_sim();
   end
endmodule

bind stream_to_legacy_frame_shim shim_checker chk (.*);
`default_nettype wire
